// ===== include/tone_pkg.sv
// Shared constants, tables, types and the contrast curve function of the tone curve stage.
`default_nettype none
package tone_pkg;

    localparam logic [4:0]  LAST_KNOT      = 5'h12;
    localparam logic [4:0]  VAR_ID_MODE    = 5'h07;
    localparam logic [7:0]  OFS_SEL_A      = 8'h43;
    localparam logic [7:0]  OFS_SEL_B      = 8'h44;
    localparam logic [7:0]  OFS_USER_BASE  = 8'h50;
    localparam logic [7:0]  OFS_CURVE_BASE = 8'h70;
    localparam logic [7:0]  SEL_RESET      = 8'h00;
    localparam int          GAMMA_LSB      = 0;
    localparam int          CONTRAST_LSB   = 4;

    localparam logic [2:0]  GAMMA_IDENT    = 3'h0;
    localparam logic [2:0]  GAMMA_056      = 3'h1;
    localparam logic [2:0]  GAMMA_045      = 3'h2;
    localparam logic [2:0]  GAMMA_USER     = 3'h3;
    localparam logic [2:0]  CONTRAST_OFF   = 3'h0;
    localparam logic [2:0]  CONTRAST_NR    = 3'h4;

    localparam logic [11:0] KNOT_1         = 12'h040;
    localparam logic [11:0] KNOT_2         = 12'h080;
    localparam logic [11:0] KNOT_3         = 12'h100;
    localparam logic [11:0] KNOT_TOP       = 12'hF00;
    localparam logic [11:0] KNOT_MAX       = 12'hFFF;
    localparam logic [4:0]  SEG_COARSE_OFS = 5'h02;
    localparam logic [4:0]  SEG_TOP        = 5'h11;
    localparam logic [16:0] RECIP_255      = 17'h00101;
    localparam logic [16:0] ROUND_TOP      = 17'h00080;
    localparam logic signed [18:0] ROUND_Q8 = 19'sh00080;
    localparam logic signed [18:0] MID_BIAS = 19'sh00080;
    localparam logic signed [8:0]  MID_X    = 9'sh080;
    localparam logic [26:0] HALF_Q16       = 27'h0008000;

    typedef logic [18:0][7:0] tone_curve_t;
    typedef enum logic {BUILD_IDLE, BUILD_RUN} build_phase_t;

    typedef struct packed {
        logic             valid;
        logic [2:0][11:0] comp;
    } pix_in_t;

    typedef struct packed {
        logic            valid;
        logic [2:0][7:0] comp;
    } pix_out_t;

    localparam tone_curve_t GAMMA_IDENT_TBL = {8'hFF, 8'hEF, 8'hDF, 8'hCF, 8'hBF, 8'hAF, 8'h9F,
        8'h8F, 8'h80, 8'h70, 8'h60, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10, 8'h08, 8'h04, 8'h00};
    localparam tone_curve_t GAMMA_056_TBL = {8'hFF, 8'hF6, 8'hED, 8'hE3, 8'hD9, 8'hCF, 8'hC4,
        8'hB9, 8'hAD, 8'hA1, 8'h93, 8'h85, 8'h75, 8'h64, 8'h50, 8'h36, 8'h25, 8'h19, 8'h00};
    localparam tone_curve_t GAMMA_045_TBL = {8'hFF, 8'hF8, 8'hF0, 8'hE8, 8'hE0, 8'hD7, 8'hCE,
        8'hC5, 8'hBB, 8'hB0, 8'hA4, 8'h97, 8'h89, 8'h78, 8'h64, 8'h49, 8'h36, 8'h27, 8'h00};

    // Contrast settings 1 to 4: midsection slope, shadow coefficient and junction point.
    localparam logic [4:0][8:0]  MID_Q8     = {9'h120, 9'h1C0, 9'h180, 9'h140, 9'h100};
    localparam logic [4:0][10:0] SHADOW_Q16 = {11'h510, 11'h20B, 11'h240, 11'h320, 11'h000};
    localparam logic [4:0][7:0]  JUNC       = {8'h1C, 8'h6D, 8'h55, 8'h33, 8'h00};

    // The end curves are a*v^2 mirrored at white, so slope is zero at both ends.
    function automatic logic [7:0] scurve(input logic [7:0] v, input logic [2:0] c);
        logic [26:0]        sq;
        logic signed [18:0] mid;
        logic signed [8:0]  d;
        logic [7:0]         w;
        sq  = '0;
        mid = '0;
        w   = 8'hFF - v;
        d   = $signed({1'b0, v}) - MID_X;
        if (c == CONTRAST_OFF || c > CONTRAST_NR) begin
            return v;
        end
        if (v <= JUNC[c]) begin
            sq = 27'(SHADOW_Q16[c]) * 27'(v) * 27'(v) + HALF_Q16;
            return sq[23:16];
        end
        if (w <= JUNC[c]) begin
            sq = 27'(SHADOW_Q16[c]) * 27'(w) * 27'(w) + HALF_Q16;
            return 8'hFF - sq[23:16];
        end
        mid = 19'($signed({10'h000, MID_Q8[c]}) * 19'(d)) + ROUND_Q8;
        mid = (mid >>> 8) + MID_BIAS;
        if (mid < 0) begin
            return 8'h00;
        end
        if (mid > 19'sh000FF) begin
            return 8'hFF;
        end
        return mid[7:0];
    endfunction

endpackage
`default_nettype wire

// ===== hdl/tone_interp.sv
// Piecewise-linear lookup of one 12-bit component through the 19-knot curve.
`timescale 1ns/1ns
`default_nettype none
module tone_interp (
    // Curve and sample
    input  wire tone_pkg::tone_curve_t curve_i,
    input  wire logic [11:0]           x_i,
    // Result
    output logic [7:0]                 y_o
);
    logic [4:0]         seg;
    logic [8:0]         t;
    logic [16:0]        tprod;
    logic signed [8:0]  dy;
    logic signed [18:0] acc;

    always_comb begin
        tprod = 17'(x_i[7:0]) * tone_pkg::RECIP_255 + tone_pkg::ROUND_TOP;
        if (x_i < tone_pkg::KNOT_1) begin
            seg = 5'h00;
            t   = {1'b0, x_i[5:0], 2'b00};
        end else if (x_i < tone_pkg::KNOT_2) begin
            seg = 5'h01;
            t   = {1'b0, x_i[5:0], 2'b00};
        end else if (x_i < tone_pkg::KNOT_3) begin
            seg = 5'h02;
            t   = {1'b0, x_i[6:0], 1'b0};
        end else if (x_i < tone_pkg::KNOT_TOP) begin
            seg = {1'b0, x_i[11:8]} + tone_pkg::SEG_COARSE_OFS;
            t   = {1'b0, x_i[7:0]};
        end else begin
            // The last span is 255 wide; a reciprocal multiply avoids a divider.
            seg = tone_pkg::SEG_TOP;
            t   = tprod[16:8];
        end
        dy  = $signed({1'b0, curve_i[seg + 5'h01]}) - $signed({1'b0, curve_i[seg]});
        acc = $signed({3'b000, curve_i[seg], 8'h00}) + 19'(dy * $signed({1'b0, t})) + tone_pkg::ROUND_Q8;
        y_o = acc[15:8];
    end
endmodule
`default_nettype wire

// ===== hdl/gamma_contrast_tone_curve.sv
// Gamma and contrast tone curve stage with its mode variable port.
`timescale 1ns/1ns
`default_nettype none
module gamma_contrast_tone_curve (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Operating mode
    input  wire logic              mode_b_i,
    // Variable access
    input  wire logic              var_we_i,
    input  wire logic              var_re_i,
    input  wire logic [4:0]        var_id_i,
    input  wire logic [7:0]        var_offset_i,
    input  wire logic [7:0]        var_wdata_i,
    output logic [7:0]             var_rdata_o,
    output logic                   var_rvalid_o,
    // Status
    output logic                   build_busy_o,
    // Pixels
    input  wire tone_pkg::pix_in_t pix_i,
    output tone_pkg::pix_out_t     pix_o
);
    typedef struct packed {
        tone_pkg::build_phase_t phase;
        logic                   busy;
        logic [4:0]             idx;
        logic                   dirty;
        logic [7:0]             build_sel;
        logic [7:0]             sel_a;
        logic [7:0]             sel_b;
        logic                   mode_b_seen;
        tone_pkg::tone_curve_t  user_tbl;
        tone_pkg::tone_curve_t  curve;
        tone_pkg::pix_out_t     pix;
        logic [7:0]             rdata;
        logic                   rvalid;
    } tone_state_t;

    tone_state_t     s;
    tone_state_t     s_next;
    logic [2:0][7:0] y;
    logic [7:0]      base;
    logic [7:0]      sel_active;
    logic [2:0]      gamma_f;
    logic [2:0]      contrast_f;
    logic            id_hit;
    logic            wr_mapped;

    function automatic logic in_table(input logic [7:0] ofs, input logic [7:0] first);
        return ofs >= first && ofs <= first + {3'b000, tone_pkg::LAST_KNOT};
    endfunction

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_comp
            tone_interp u_interp (
                .curve_i (s.curve),
                .x_i     (pix_i.comp[g]),
                .y_o     (y[g])
            );
        end
    endgenerate

    always_comb begin
        s_next     = s;
        s_next.rvalid = 1'b0;
        sel_active = s.mode_b_seen ? s.sel_b : s.sel_a;
        gamma_f    = s.build_sel[tone_pkg::GAMMA_LSB +: 3];
        contrast_f = s.build_sel[tone_pkg::CONTRAST_LSB +: 3];
        id_hit     = var_id_i == tone_pkg::VAR_ID_MODE;
        wr_mapped  = 1'b0;
        case (gamma_f)
            tone_pkg::GAMMA_056:  base = tone_pkg::GAMMA_056_TBL[s.idx];
            tone_pkg::GAMMA_045:  base = tone_pkg::GAMMA_045_TBL[s.idx];
            tone_pkg::GAMMA_USER: base = s.user_tbl[s.idx];
            default:              base = tone_pkg::GAMMA_IDENT_TBL[s.idx];
        endcase
        if (var_we_i && id_hit) begin
            if (var_offset_i == tone_pkg::OFS_SEL_A) begin
                s_next.sel_a = var_wdata_i;
                wr_mapped    = 1'b1;
            end else if (var_offset_i == tone_pkg::OFS_SEL_B) begin
                s_next.sel_b = var_wdata_i;
                wr_mapped    = 1'b1;
            end else if (in_table(var_offset_i, tone_pkg::OFS_USER_BASE)) begin
                s_next.user_tbl[5'(var_offset_i - tone_pkg::OFS_USER_BASE)] = var_wdata_i;
                wr_mapped = 1'b1;
            end
        end
        if (var_re_i) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = 8'h00;
            if (!id_hit) begin
                s_next.rdata = 8'h00;
            end else if (var_offset_i == tone_pkg::OFS_SEL_A) begin
                s_next.rdata = s.sel_a;
            end else if (var_offset_i == tone_pkg::OFS_SEL_B) begin
                s_next.rdata = s.sel_b;
            end else if (in_table(var_offset_i, tone_pkg::OFS_USER_BASE)) begin
                s_next.rdata = s.user_tbl[5'(var_offset_i - tone_pkg::OFS_USER_BASE)];
            end else if (in_table(var_offset_i, tone_pkg::OFS_CURVE_BASE)) begin
                s_next.rdata = s.curve[5'(var_offset_i - tone_pkg::OFS_CURVE_BASE)];
            end
        end
        // Pixels keep flowing during a rebuild, so a frame may see a mix of old and new knots.
        case (s.phase)
            tone_pkg::BUILD_IDLE: begin
                if (s.dirty) begin
                    s_next.phase     = tone_pkg::BUILD_RUN;
                    s_next.busy      = 1'b1;
                    s_next.idx       = 5'h00;
                    s_next.build_sel = sel_active;
                    s_next.dirty     = 1'b0;
                end
            end
            tone_pkg::BUILD_RUN: begin
                s_next.curve[s.idx] = tone_pkg::scurve(base, contrast_f);
                s_next.idx = s.idx + 5'h01;
                if (s.idx == tone_pkg::LAST_KNOT) begin
                    s_next.phase = tone_pkg::BUILD_IDLE;
                    s_next.busy  = 1'b0;
                end
            end
            default: begin
                s_next.phase = tone_pkg::BUILD_IDLE;
                s_next.busy  = 1'b0;
            end
        endcase
        // A change arriving while the flag is being consumed still forces another pass.
        s_next.mode_b_seen = mode_b_i;
        if (wr_mapped || mode_b_i != s.mode_b_seen) begin
            s_next.dirty = 1'b1;
        end
        s_next.pix.valid = pix_i.valid;
        if (pix_i.valid) begin
            s_next.pix.comp = y;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s          <= '0;
            s.dirty    <= 1'b1;
            s.sel_a    <= tone_pkg::SEL_RESET;
            s.sel_b    <= tone_pkg::SEL_RESET;
            s.user_tbl <= tone_pkg::GAMMA_IDENT_TBL;
        end else begin
            s <= s_next;
        end
    end

    assign var_rdata_o  = s.rdata;
    assign var_rvalid_o = s.rvalid;
    assign build_busy_o = s.busy;
    assign pix_o        = s.pix;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    top_knot_a: assert property (pix_i.valid && pix_i.comp[0] == tone_pkg::KNOT_MAX && !s.busy
        |=> pix_o.comp[0] == $past(s.curve[tone_pkg::LAST_KNOT])) else $error("top knot wrong");
    rgb_same_a: assert property (pix_i.valid && pix_i.comp[0] == pix_i.comp[1]
        && pix_i.comp[1] == pix_i.comp[2] |=> pix_o.comp[0] == pix_o.comp[1]
        && pix_o.comp[1] == pix_o.comp[2]) else $error("channels differ");
    sel_write_a: assert property (var_we_i && id_hit && var_offset_i == tone_pkg::OFS_SEL_B
        |=> s.sel_b == $past(var_wdata_i) ##1 s.dirty || s.busy) else $error("mode B byte lost");
    build_len_a: assert property ($rose(build_busy_o) |-> build_busy_o[*8] ##12 !build_busy_o)
        else $error("build length wrong");
    knot_merge_a: assert property (s.busy |=> s.curve[$past(s.idx)]
        == tone_pkg::scurve($past(base), $past(contrast_f))) else $error("knot not merged");
    black_end_a: assert property (s.busy && base == 8'h00 |=> s.curve[$past(s.idx)] == 8'h00)
        else $error("black end moved");
    white_end_a: assert property (s.busy && base == 8'hFF |=> s.curve[$past(s.idx)] == 8'hFF)
        else $error("white end moved");
    pass_through_a: assert property (s.busy && contrast_f == tone_pkg::CONTRAST_OFF
        |=> s.curve[$past(s.idx)] == $past(base)) else $error("contrast off altered");
    mid_stretch_a: assert property (s.busy && contrast_f != tone_pkg::CONTRAST_OFF
        && contrast_f < tone_pkg::CONTRAST_NR && base == 8'hA0
        |=> s.curve[$past(s.idx)] > 8'hA0) else $error("midtone not stretched");
    user_pick_a: assert property (s.busy && gamma_f == tone_pkg::GAMMA_USER
        && contrast_f == tone_pkg::CONTRAST_OFF |=> s.curve[$past(s.idx)]
        == $past(s.user_tbl[s.idx])) else $error("user table ignored");

    build_c: cover property ($rose(build_busy_o) ##[19:30] !build_busy_o);
    top_seg_c: cover property (pix_i.valid && pix_i.comp[0] > tone_pkg::KNOT_TOP);
    user_c: cover property (s.busy && gamma_f == tone_pkg::GAMMA_USER);
    mode_c: cover property (mode_b_i != s.mode_b_seen);
endmodule
`default_nettype wire

// ===== testbench/pix_partner.sv
// Upstream pixel source and downstream pixel capture for the tone curve stage.
`timescale 1ns/1ns
`default_nettype none
module pix_partner (
    // Clock
    input  wire logic               clk_i,
    // Pixels
    output var tone_pkg::pix_in_t   src_o,
    input  wire tone_pkg::pix_out_t snk_i
);
    tone_pkg::pix_out_t got[$];

    initial src_o = '0;

    always @(posedge clk_i) begin
        if (snk_i.valid === 1'b1) begin
            got.push_back(snk_i);
        end
    end

    // Released lines show inverted data, so a design that samples them late is caught.
    // With same set, all three components carry one value, so the channels can be compared.
    task automatic stream(input logic [11:0] xs[$], input bit same);
        foreach (xs[i]) begin
            @(posedge clk_i);
            #1;
            src_o.valid = 1'b1;
            src_o.comp  = same ? {3{xs[i]}} : {xs[i], ~xs[i], xs[i] ^ 12'h0F0};
        end
        @(posedge clk_i);
        #1;
        src_o.valid = 1'b0;
        src_o.comp  = ~src_o.comp;
        @(posedge clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== testbench/gamma_contrast_tone_curve_tb_top.sv
// Self-checking bench for the gamma and contrast tone curve stage.
`timescale 1ns/1ns
`default_nettype none
module gamma_contrast_tone_curve_tb_top;
    localparam logic [4:0] ID    = tone_pkg::VAR_ID_MODE;
    localparam int         MQ[5] = '{256, 320, 384, 448, 288};
    localparam int         AQ[5] = '{0, 800, 576, 523, 1296};
    localparam int         JQ[5] = '{0, 51, 85, 109, 28};
    logic                  clk_i = 1'b0;
    logic                  rst_i, mode_b_i, var_we_i, var_re_i, var_rvalid_o, build_busy_o;
    logic [4:0]            var_id_i;
    logic [7:0]            var_offset_i, var_wdata_i, var_rdata_o, rd;
    tone_pkg::pix_in_t     pix_i;
    tone_pkg::pix_out_t    pix_o;
    tone_pkg::tone_curve_t user_tbl, exp_curve;
    int                    err_count = 0;
    int                    tests_run = 0;
    int                    cycles = 0;
    logic [11:0]           xs[$] = '{12'h000, 12'h020, 12'h040, 12'h064, 12'h080, 12'h0C8,
        12'h100, 12'h3E8, 12'hF00, 12'hF3C, 12'hFFF};

    gamma_contrast_tone_curve u_gamma_contrast_tone_curve (.clk_i(clk_i), .rst_i(rst_i),
        .mode_b_i(mode_b_i), .var_we_i(var_we_i), .var_re_i(var_re_i), .var_id_i(var_id_i),
        .var_offset_i(var_offset_i), .var_wdata_i(var_wdata_i), .var_rdata_o(var_rdata_o),
        .var_rvalid_o(var_rvalid_o), .build_busy_o(build_busy_o), .pix_i(pix_i), .pix_o(pix_o));
    pix_partner u_pix_partner (.clk_i(clk_i), .src_o(pix_i), .snk_i(pix_o));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic vwr(input logic [4:0] id, input logic [7:0] o, input logic [7:0] d);
        var_we_i     = 1'b1;
        var_id_i     = id;
        var_offset_i = o;
        var_wdata_i  = d;
        tick();
        var_we_i = 1'b0;
        tick();
    endtask

    task automatic vrd(input logic [4:0] id, input logic [7:0] o);
        var_re_i     = 1'b1;
        var_id_i     = id;
        var_offset_i = o;
        tick();
        var_re_i = 1'b0;
        rd       = var_rdata_o;
        check("rvalid", 8'(var_rvalid_o), 8'h01);
        tick();
    endtask

    // The first wait allows for the cycles before a pending rebuild raises build_busy_o.
    task automatic wait_build(input bit f);
        int n;
        n = 0;
        while (build_busy_o !== 1'b1 && n < 25) begin
            tick();
            n++;
        end
        n = 0;
        while (build_busy_o === 1'b1 && n < 40) begin
            tick();
            n++;
        end
        if (f) check("build_cycles", 8'(n), 8'h13);
    endtask

    function automatic logic [7:0] sc(input int v, input int c);
        int y;
        if (c < 1 || c > 4) return 8'(v);
        if (v <= JQ[c]) return 8'((AQ[c] * v * v + 32768) >>> 16);
        if (255 - v <= JQ[c]) return 8'(255 - ((AQ[c] * (255 - v) * (255 - v) + 32768) >>> 16));
        y = ((MQ[c] * (v - 128) + 128) >>> 8) + 128;
        return y < 0 ? 8'h00 : (y > 255 ? 8'hFF : 8'(y));
    endfunction

    function automatic logic [7:0] interp(input tone_pkg::tone_curve_t cv, input logic [11:0] x);
        int xi, s, t, lo, hi;
        xi = x;
        s  = xi < 128 ? xi / 64 : (xi < 256 ? 2 : xi / 256 + 2);
        t  = xi - (s < 3 ? s * 64 : (s - 2) * 256);
        t  = s < 2 ? t * 4 : (s == 2 ? t * 2 : (s == 17 ? (t * 257 + 128) >> 8 : t));
        lo = cv[s];
        hi = cv[s + 1];
        return 8'((lo * 256 + (hi - lo) * t + 128) >>> 8);
    endfunction

    function automatic void build_exp(input int g, input int c);
        tone_pkg::tone_curve_t b;
        b = g == 1 ? tone_pkg::GAMMA_056_TBL : (g == 2 ? tone_pkg::GAMMA_045_TBL :
            (g == 3 ? user_tbl : tone_pkg::GAMMA_IDENT_TBL));
        for (int k = 0; k <= 18; k++) begin
            exp_curve[k] = sc(b[k], c);
        end
    endfunction

    task automatic chk_curve;
        for (int k = 0; k <= 18; k++) begin
            vrd(ID, tone_pkg::OFS_CURVE_BASE + 8'(k));
            check("curve", rd, exp_curve[k]);
        end
    endtask

    task automatic chk_pix(input bit same);
        u_pix_partner.stream(xs, same);
        check("pix_count", 8'(u_pix_partner.got.size()), 8'(xs.size()));
        foreach (u_pix_partner.got[i]) begin
            check("pix_r", u_pix_partner.got[i].comp[2], interp(exp_curve, xs[i]));
            check("pix_g", u_pix_partner.got[i].comp[1],
                interp(exp_curve, same ? xs[i] : ~xs[i]));
            check("pix_b", u_pix_partner.got[i].comp[0],
                interp(exp_curve, same ? xs[i] : xs[i] ^ 12'h0F0));
        end
        u_pix_partner.got.delete();
    endtask

    task automatic t_reset;
        vrd(ID, tone_pkg::OFS_SEL_A);
        check("sel_a_rst", rd, tone_pkg::SEL_RESET);
        vrd(ID, tone_pkg::OFS_SEL_B);
        check("sel_b_rst", rd, tone_pkg::SEL_RESET);
        for (int k = 0; k <= 18; k++) begin
            vrd(ID, tone_pkg::OFS_USER_BASE + 8'(k));
            check("user_rst", rd, tone_pkg::GAMMA_IDENT_TBL[k]);
        end
        vwr(5'h06, tone_pkg::OFS_SEL_A, 8'h33);
        vwr(ID, tone_pkg::OFS_CURVE_BASE, 8'h5A);
        wait_build(0);
        vrd(5'h06, tone_pkg::OFS_SEL_A);
        check("bad_id", rd, 8'h00);
        vrd(ID, 8'h30);
        check("unmapped", rd, 8'h00);
        vrd(ID, tone_pkg::OFS_SEL_A);
        check("sel_a_kept", rd, tone_pkg::SEL_RESET);
        build_exp(0, 0);
        chk_curve();
        chk_pix(1);
    endtask

    // Every gamma and contrast code, the unused ones too, against every gamma table.
    task automatic t_tables;
        logic [7:0] sel;
        for (int k = 0; k <= 18; k++) begin
            user_tbl[k] = 8'(k * 10 + 50);
            vwr(ID, tone_pkg::OFS_USER_BASE + 8'(k), user_tbl[k]);
        end
        wait_build(0);
        wait_build(0);
        for (int k = 0; k <= 18; k++) begin
            vrd(ID, tone_pkg::OFS_USER_BASE + 8'(k));
            check("user", rd, user_tbl[k]);
        end
        for (int g = 0; g < 8; g++) begin
            for (int c = 0; c < 8; c++) begin
                sel = 8'(c * 16 + g) | (c == 1 ? 8'h88 : 8'h00);
                vwr(ID, tone_pkg::OFS_SEL_A, sel);
                wait_build(1);
                vrd(ID, tone_pkg::OFS_SEL_A);
                check("sel_a", rd, sel);
                build_exp(g, c);
                chk_curve();
                chk_pix(c[0]);
            end
        end
    endtask

    task automatic t_modes;
        vwr(ID, tone_pkg::OFS_SEL_A, 8'h12);
        wait_build(1);
        vwr(ID, tone_pkg::OFS_SEL_B, 8'h31);
        wait_build(1);
        vrd(ID, tone_pkg::OFS_SEL_B);
        check("sel_b", rd, 8'h31);
        build_exp(2, 1);
        chk_curve();
        mode_b_i = 1'b1;
        wait_build(1);
        build_exp(1, 3);
        chk_curve();
        chk_pix(0);
        mode_b_i = 1'b0;
        wait_build(1);
        build_exp(2, 1);
        chk_curve();
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        rst_i        = 1'b1;
        mode_b_i     = 1'b0;
        var_we_i     = 1'b0;
        var_re_i     = 1'b0;
        var_id_i     = 5'h00;
        var_offset_i = 8'h00;
        var_wdata_i  = 8'h00;
        repeat (4) tick();
        check("busy_rst", 8'(build_busy_o), 8'h00);
        rst_i = 1'b0;
        repeat (24) tick();
        t_reset();
        t_tables();
        t_modes();
        summarize();
    end
endmodule
`default_nettype wire
